// ==== verilog/tvfs_pkg.sv ====
package tvfs_pkg;

   // ----------------------------------------
   // command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_UT_WARN = 8'h52;
   localparam logic [7:0] CMD_UT_FAULT = 8'h53;
   localparam logic [7:0] CMD_UT_ACT = 8'h54;
   localparam logic [7:0] CMD_OV_FAULT = 8'h55;
   localparam logic [7:0] CMD_OV_ACT = 8'h56;
   localparam logic [7:0] CMD_OV_WARN = 8'h57;
   localparam logic [7:0] CMD_UV_WARN = 8'h58;
   localparam logic [7:0] CMD_UV_FAULT = 8'h59;
   localparam logic [7:0] CMD_UV_ACT = 8'h5A;
   localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
   localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
   localparam logic [7:0] CMD_STATUS_INPUT = 8'h7C;
   localparam logic [7:0] CMD_STATUS_TEMP = 8'h7D;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [15:0] RST_UT_WARN = 16'hE580;
   localparam logic [15:0] RST_UT_FAULT = 16'hE490;
   localparam logic [7:0] RST_ACT = 8'h80;
   localparam logic [15:0] RST_OV_FAULT = 16'hD3A0;
   localparam logic [15:0] RST_OV_WARN = 16'hD360;
   // 4.5 V as mantissa 9, exponent -1
   localparam logic [15:0] RST_UV_WARN = 16'hF809;

   // ----------------------------------------
   // fields and status bit positions
   // ----------------------------------------
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   localparam int SW_INPUT = 13;
   localparam int SW_OFF = 6;
   localparam int SW_VIN_UV = 3;
   localparam int SW_TEMP = 2;
   localparam int SW_NOA = 0;
   localparam int SI_OV_FAULT = 7;
   localparam int SI_OV_WARN = 6;
   localparam int SI_UV_WARN = 5;
   localparam int SI_UV_FAULT = 4;
   localparam int ST_UT_WARN = 5;
   localparam int ST_UT_FAULT = 4;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned RETRY_UNIT_NS = 1000000;
   localparam int unsigned RETRY_UNIT_CYC = RETRY_UNIT_NS / CLK_PERIOD_NS;
   localparam logic [1:0] STRAP_LOAD = 2'h2;
   localparam logic [1:0] STRAP_DONE = 2'h3;

   typedef enum logic [1:0] {
      RESP_IGNORE = 2'b00,
      RESP_DELAY = 2'b01,
      RESP_NOW = 2'b10,
      RESP_HICCUP = 2'b11
   } tvfs_resp_t;

   typedef enum logic [2:0] {
      ENG_RUN = 3'b000,
      ENG_DELAY = 3'b001,
      ENG_WAIT = 3'b010,
      ENG_HICCUP = 3'b011,
      ENG_LATCH = 3'b100
   } tvfs_eng_state_t;

   // linear-11 word to signed fixed point with 16 fraction bits
   function automatic logic signed [42:0] tvfs_l11_fix(input logic [15:0] w);
      logic signed [42:0] m;
      logic [4:0] sh;
      m = {{32{w[10]}}, w[10:0]};
      sh = w[15:11] + 5'h10;
      return m <<< sh;
   endfunction

endpackage

// ==== verilog/tvfs_fault_if.sv ====
`timescale 1ns/1ps
interface tvfs_fault_if;
   logic fault;
   logic [7:0] action;
   logic tick;
   logic rail_en;
   logic off;
   modport sup (output fault, output action, output tick, output rail_en, input off);
   modport eng (input fault, input action, input tick, input rail_en, output off);
endinterface // tvfs_fault_if

// ==== verilog/tvfs_fault_engine.sv ====
`timescale 1ns/1ps
module tvfs_fault_engine import tvfs_pkg::*; (
   input logic core_clk, // core clock
   input logic rst_b, // async reset, active low
   tvfs_fault_if.eng fi // fault in, off out
);

   typedef struct packed {
      tvfs_eng_state_t state;
      logic [2:0] cnt;
      logic [2:0] left;
      logic off;
   } tvfs_eng_t;

   tvfs_eng_t st_ff;
   tvfs_eng_t nxt_st;
   tvfs_resp_t resp;

   assign resp = tvfs_resp_t'(fi.action[7:6]);

   function automatic tvfs_eng_t shut(input tvfs_eng_t x, input logic [2:0] retry, input logic [2:0] tm);
      tvfs_eng_t y;
      y = x;
      y.off = 1'b1;
      if (retry == RETRY_NONE) begin
         y.state = ENG_LATCH;
      end else begin
         y.state = ENG_WAIT;
         y.cnt = tm;
         y.left = retry;
      end
      return y;
   endfunction

   // ----------------------------------------
   // response sequencer
   // ----------------------------------------
   always_comb begin
      nxt_st = st_ff;
      case (st_ff.state)
         ENG_RUN: begin
            nxt_st.off = 1'b0;
            if (fi.fault) begin
               case (resp)
                  RESP_DELAY: begin
                     nxt_st.state = ENG_DELAY;
                     nxt_st.cnt = fi.action[2:0];
                  end
                  RESP_NOW: nxt_st = shut(st_ff, fi.action[5:3], fi.action[2:0]);
                  RESP_HICCUP: begin
                     nxt_st.state = ENG_HICCUP;
                     nxt_st.off = 1'b1;
                  end
                  default: nxt_st.off = 1'b0;
               endcase
            end
         end
         ENG_DELAY: begin
            if (!fi.fault) begin
               nxt_st.state = ENG_RUN;
            end else if (st_ff.cnt == 3'h0) begin
               nxt_st = shut(st_ff, fi.action[5:3], fi.action[2:0]);
            end else if (fi.tick) begin
               nxt_st.cnt = st_ff.cnt - 3'h1;
            end
         end
         ENG_WAIT: begin
            if (st_ff.cnt != 3'h0) begin
               if (fi.tick) begin
                  nxt_st.cnt = st_ff.cnt - 3'h1;
               end
            end else if (st_ff.left == RETRY_FOREVER || !fi.fault) begin
               // forever mode restarts blind; a live fault re-trips next cycle
               nxt_st.state = ENG_RUN;
               nxt_st.off = 1'b0;
            end else if (st_ff.left == 3'h1) begin
               nxt_st.state = ENG_LATCH;
            end else begin
               nxt_st.left = st_ff.left - 3'h1;
               nxt_st.cnt = fi.action[2:0];
            end
         end
         ENG_HICCUP: begin
            if (!fi.fault) begin
               nxt_st.state = ENG_RUN;
               nxt_st.off = 1'b0;
            end
         end
         ENG_LATCH: nxt_st.off = 1'b1;
         default: nxt_st.state = ENG_RUN;
      endcase
      // disabling the rail is the restart that ends any response
      if (!fi.rail_en) begin
         nxt_st.state = ENG_RUN;
         nxt_st.off = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '{state: ENG_RUN, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign fi.off = st_ff.off;

   ignore_keeps_on_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      st_ff.state == ENG_RUN && resp == RESP_IGNORE && fi.rail_en |=> !st_ff.off)
      else $error("ignored fault turned output off");
   now_turns_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      st_ff.state == ENG_RUN && fi.fault && resp == RESP_NOW && fi.rail_en |=> st_ff.off)
      else $error("immediate response did not disable");
   latch_holds_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      st_ff.state == ENG_LATCH && fi.rail_en |=> st_ff.off && st_ff.state == ENG_LATCH)
      else $error("latched off released without restart");

endmodule // tvfs_fault_engine

// ==== verilog/tvfs_supervisor.sv ====
`timescale 1ns/1ps

module tvfs_supervisor import tvfs_pkg::*; #(
   parameter int unsigned TICK_CYC = RETRY_UNIT_CYC
) (
   input logic core_clk, // 20 MHz clock
   input logic rst_b, // async reset, active low
   input logic cmd_valid, // command strobe
   input logic cmd_wr, // 1 write, 0 read
   input logic [7:0] cmd_code, // command code
   input logic [15:0] cmd_wdata, // write word or byte
   output logic rsp_valid, // answer strobe
   output logic [15:0] rsp_data, // read data
   output logic rsp_err, // unsupported access
   input logic [15:0] temp_l11, // temperature sample
   input logic [15:0] vin_l11, // input voltage sample
   input logic sample_valid, // samples valid
   input logic rail_en, // rail enable from control
   input logic [15:0] uv_strap_l11, // strap pins
   output logic pwr_en, // output stage enable
   output logic smbalert_b // host alert, active low
);

   typedef struct packed {
      logic [15:0] ut_warn;
      logic [15:0] ut_fault;
      logic [7:0] ut_act;
      logic [15:0] ov_fault;
      logic [7:0] ov_act;
      logic [15:0] ov_warn;
      logic [15:0] uv_warn;
      logic [15:0] uv_fault;
      logic [7:0] uv_act;
      logic [7:0] stat_in;
      logic [7:0] stat_temp;
      logic ut_live;
      logic ov_live;
      logic uv_live;
      logic [15:0] strap_s1;
      logic [15:0] strap_s2;
      logic [1:0] strap_cnt;
      logic [14:0] tick_cnt;
      logic tick;
      logic rsp_valid;
      logic rsp_err;
      logic [15:0] rsp_data;
      logic alert_b;
      logic out_en;
   } tvfs_sup_t;

   localparam tvfs_sup_t SUP_RST = '{
      ut_warn: RST_UT_WARN,
      ut_fault: RST_UT_FAULT,
      ut_act: RST_ACT,
      ov_fault: RST_OV_FAULT,
      ov_act: RST_ACT,
      ov_warn: RST_OV_WARN,
      uv_warn: RST_UV_WARN,
      uv_act: RST_ACT,
      alert_b: 1'b1,
      default: '0
   };

   tvfs_sup_t st_ff;
   tvfs_sup_t nxt_st;

   // ----------------------------------------
   // status summary
   // ----------------------------------------
   function automatic logic [15:0] status_word(input tvfs_sup_t s);
      logic [15:0] w;
      w = 16'h0000;
      w[SW_INPUT] = |s.stat_in;
      w[SW_OFF] = ~s.out_en;
      w[SW_VIN_UV] = s.stat_in[SI_UV_FAULT];
      w[SW_TEMP] = |s.stat_temp;
      // of the input events only the UV fault has a bit in 7:1 (bit 3), so NOA is set for every input event
      w[SW_NOA] = |s.stat_in;
      return w;
   endfunction

   // ----------------------------------------
   // comparisons
   // ----------------------------------------
   logic signed [42:0] temp_fx;
   logic signed [42:0] vin_fx;
   logic signed [42:0] utw_fx;
   logic signed [42:0] utf_fx;
   logic signed [42:0] ovf_fx;
   logic signed [42:0] ovw_fx;
   logic signed [42:0] uvw_fx;
   logic signed [42:0] uvf_fx;
   logic ut_warn_hit;
   logic ut_fault_hit;
   logic ut_clear;
   logic ov_fault_hit;
   logic ov_warn_hit;
   logic uv_warn_hit;
   logic uv_fault_hit;
   logic uv_clear;
   logic clear_cmd;
   logic [15:0] stat_word;

   // exponents differ between words, so compare after alignment
   assign temp_fx = tvfs_l11_fix(temp_l11);
   assign vin_fx = tvfs_l11_fix(vin_l11);
   assign utw_fx = tvfs_l11_fix(st_ff.ut_warn);
   assign utf_fx = tvfs_l11_fix(st_ff.ut_fault);
   assign ovf_fx = tvfs_l11_fix(st_ff.ov_fault);
   assign ovw_fx = tvfs_l11_fix(st_ff.ov_warn);
   assign uvw_fx = tvfs_l11_fix(st_ff.uv_warn);
   assign uvf_fx = tvfs_l11_fix(st_ff.uv_fault);

   assign ut_warn_hit = temp_fx < utw_fx;
   assign ut_fault_hit = temp_fx < utf_fx;
   assign ut_clear = temp_fx > utw_fx;
   assign ov_fault_hit = vin_fx > ovf_fx;
   assign ov_warn_hit = vin_fx > ovw_fx;
   assign uv_warn_hit = vin_fx < uvw_fx;
   assign uv_fault_hit = vin_fx < uvf_fx;
   assign uv_clear = vin_fx > uvw_fx;
   assign clear_cmd = cmd_valid && cmd_wr && cmd_code == CMD_CLEAR_FAULTS;
   assign stat_word = status_word(st_ff);

   // ----------------------------------------
   // response engines: ut, vin ov, vin uv
   // ----------------------------------------
   logic [2:0] live_vec;
   logic [2:0][7:0] act_vec;
   logic [2:0] eng_off;

   assign live_vec = {st_ff.uv_live, st_ff.ov_live, st_ff.ut_live};
   assign act_vec = {st_ff.uv_act, st_ff.ov_act, st_ff.ut_act};

   tvfs_fault_if fif[3] ();

   for (genvar g = 0; g < 3; g++) begin : g_eng
      assign fif[g].fault = live_vec[g];
      assign fif[g].action = act_vec[g];
      assign fif[g].tick = st_ff.tick;
      assign fif[g].rail_en = rail_en;
      assign eng_off[g] = fif[g].off;
      tvfs_fault_engine u_eng (
         .core_clk(core_clk),
         .rst_b(rst_b),
         .fi(fif[g])
      );
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_st = st_ff;

      // time unit for delay and retry spacing
      nxt_st.tick = 1'b0;
      if (st_ff.tick_cnt == 15'(TICK_CYC - 1)) begin
         nxt_st.tick_cnt = 15'h0000;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.tick_cnt = st_ff.tick_cnt + 15'h0001;
      end

      // strap pins are synchronised, then taken once
      nxt_st.strap_s1 = uv_strap_l11;
      nxt_st.strap_s2 = st_ff.strap_s1;
      if (st_ff.strap_cnt != STRAP_DONE) begin
         nxt_st.strap_cnt = st_ff.strap_cnt + 2'h1;
      end
      if (st_ff.strap_cnt == STRAP_LOAD) begin
         nxt_st.uv_fault = st_ff.strap_s2;
      end

      // command port
      nxt_st.rsp_valid = cmd_valid;
      nxt_st.rsp_err = 1'b0;
      nxt_st.rsp_data = 16'h0000;
      if (cmd_valid && cmd_wr) begin
         case (cmd_code)
            CMD_CLEAR_FAULTS: nxt_st.rsp_err = 1'b0;
            CMD_UT_WARN: nxt_st.ut_warn = cmd_wdata;
            CMD_UT_FAULT: nxt_st.ut_fault = cmd_wdata;
            CMD_UT_ACT: nxt_st.ut_act = cmd_wdata[7:0];
            CMD_OV_FAULT: nxt_st.ov_fault = cmd_wdata;
            CMD_OV_ACT: nxt_st.ov_act = cmd_wdata[7:0];
            CMD_OV_WARN: nxt_st.ov_warn = cmd_wdata;
            CMD_UV_WARN: nxt_st.uv_warn = cmd_wdata;
            CMD_UV_FAULT: nxt_st.uv_fault = cmd_wdata;
            CMD_UV_ACT: nxt_st.uv_act = cmd_wdata[7:0];
            default: nxt_st.rsp_err = 1'b1;
         endcase
      end
      if (cmd_valid && !cmd_wr) begin
         case (cmd_code)
            CMD_UT_WARN: nxt_st.rsp_data = st_ff.ut_warn;
            CMD_UT_FAULT: nxt_st.rsp_data = st_ff.ut_fault;
            CMD_UT_ACT: nxt_st.rsp_data = {8'h00, st_ff.ut_act};
            CMD_OV_FAULT: nxt_st.rsp_data = st_ff.ov_fault;
            CMD_OV_ACT: nxt_st.rsp_data = {8'h00, st_ff.ov_act};
            CMD_OV_WARN: nxt_st.rsp_data = st_ff.ov_warn;
            CMD_UV_WARN: nxt_st.rsp_data = st_ff.uv_warn;
            CMD_UV_FAULT: nxt_st.rsp_data = st_ff.uv_fault;
            CMD_UV_ACT: nxt_st.rsp_data = {8'h00, st_ff.uv_act};
            CMD_STATUS_BYTE: nxt_st.rsp_data = {8'h00, stat_word[7:0]};
            CMD_STATUS_WORD: nxt_st.rsp_data = stat_word;
            CMD_STATUS_INPUT: nxt_st.rsp_data = {8'h00, st_ff.stat_in};
            CMD_STATUS_TEMP: nxt_st.rsp_data = {8'h00, st_ff.stat_temp};
            default: nxt_st.rsp_err = 1'b1;
         endcase
      end

      // live fault conditions, with hysteresis on the low limits
      if (sample_valid) begin
         if (ut_fault_hit) begin
            nxt_st.ut_live = 1'b1;
         end else if (ut_clear) begin
            nxt_st.ut_live = 1'b0;
         end
         nxt_st.ov_live = ov_fault_hit;
         if (uv_fault_hit) begin
            nxt_st.uv_live = 1'b1;
         end else if (uv_clear) begin
            nxt_st.uv_live = 1'b0;
         end
      end

      // sticky status; a set in the clear cycle survives
      if (clear_cmd) begin
         nxt_st.stat_in = 8'h00;
         nxt_st.stat_temp = 8'h00;
      end
      if (sample_valid) begin
         nxt_st.stat_temp[ST_UT_WARN] = nxt_st.stat_temp[ST_UT_WARN] | ut_warn_hit;
         nxt_st.stat_in[SI_OV_WARN] = nxt_st.stat_in[SI_OV_WARN] | ov_warn_hit;
         nxt_st.stat_in[SI_UV_WARN] = nxt_st.stat_in[SI_UV_WARN] | uv_warn_hit;
      end
      nxt_st.stat_temp[ST_UT_FAULT] = nxt_st.stat_temp[ST_UT_FAULT] | nxt_st.ut_live;
      nxt_st.stat_in[SI_OV_FAULT] = nxt_st.stat_in[SI_OV_FAULT] | nxt_st.ov_live;
      nxt_st.stat_in[SI_UV_FAULT] = nxt_st.stat_in[SI_UV_FAULT] | nxt_st.uv_live;

      // alert stays low while anything is latched
      nxt_st.alert_b = ~(|nxt_st.stat_in | |nxt_st.stat_temp);
      nxt_st.out_en = rail_en & ~(|eng_off);
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= SUP_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rsp_valid = st_ff.rsp_valid;
   assign rsp_data = st_ff.rsp_data;
   assign rsp_err = st_ff.rsp_err;
   assign pwr_en = st_ff.out_en;
   assign smbalert_b = st_ff.alert_b;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   ut_warn_sets_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      sample_valid && ut_warn_hit |=> st_ff.stat_temp[ST_UT_WARN] && !smbalert_b && stat_word[SW_TEMP])
      else $error("under-temperature warning not reported");
   ut_fault_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      st_ff.ut_live && !(sample_valid && ut_clear) |=> st_ff.ut_live)
      else $error("under-temperature fault cleared early");
   sticky_fault_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      st_ff.stat_in[SI_OV_FAULT] && !clear_cmd |=> st_ff.stat_in[SI_OV_FAULT])
      else $error("fault bit dropped without clear");
   ov_warn_sets_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      sample_valid && ov_warn_hit |=> st_ff.stat_in[SI_OV_WARN] && stat_word[SW_NOA] && stat_word[SW_INPUT])
      else $error("overvoltage warning not reported");
   uv_fault_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      st_ff.uv_live && !(sample_valid && uv_clear) |=> st_ff.uv_live)
      else $error("undervoltage fault cleared early");
   strap_load_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      st_ff.strap_cnt == STRAP_LOAD && !(cmd_valid && cmd_wr) |=> st_ff.uv_fault == $past(st_ff.strap_s2))
      else $error("strap value not taken");
   alert_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !smbalert_b && !clear_cmd |=> !smbalert_b)
      else $error("alert released without clear");
   rsp_answer_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      cmd_valid |=> rsp_valid)
      else $error("command got no answer");
   rsp_idle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !cmd_valid |=> !rsp_valid && !rsp_err && rsp_data == 16'h0000)
      else $error("answer without command");
   status_wr_refused_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      cmd_valid && cmd_wr && cmd_code == CMD_STATUS_WORD |=> rsp_err)
      else $error("status write not refused");
   read_back_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      cmd_valid && !cmd_wr && cmd_code == CMD_UT_WARN |=> !rsp_err && rsp_data == $past(st_ff.ut_warn))
      else $error("threshold read back wrong");
   ut_fault_sets_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      sample_valid && ut_fault_hit |=> st_ff.ut_live && st_ff.stat_temp[ST_UT_FAULT] && stat_word[SW_TEMP])
      else $error("under-temperature fault not declared");
   ov_fault_sets_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      sample_valid && ov_fault_hit |=> st_ff.ov_live && st_ff.stat_in[SI_OV_FAULT])
      else $error("overvoltage fault not declared");
   uv_warn_sets_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      sample_valid && uv_warn_hit |=> st_ff.stat_in[SI_UV_WARN] && stat_word[SW_NOA] && stat_word[SW_INPUT])
      else $error("undervoltage warning not reported");
   event_alerts_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      sample_valid && (ut_warn_hit || ov_warn_hit || uv_warn_hit) |=> !smbalert_b)
      else $error("warning without alert");
   clear_releases_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      clear_cmd && !sample_valid && !(|live_vec) |=> smbalert_b)
      else $error("clear left alert asserted");
   rail_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !rail_en |=> !pwr_en)
      else $error("output on while rail disabled");
   rail_on_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      rail_en && !(|eng_off) |=> pwr_en)
      else $error("output off with no engine holding it");

endmodule // tvfs_supervisor

// ==== tb/tvfs_host_model.sv ====
`timescale 1ns/1ps
// --------
// host side of the command port
// --------
module tvfs_host_model (
   input wire logic core_clk, // clock
   output logic cmd_valid, // strobe
   output logic cmd_wr, // direction
   output logic [7:0] cmd_code, // code
   output logic [15:0] cmd_wdata, // data
   input wire logic rsp_valid, // answer strobe
   input wire logic [15:0] rsp_data, // read data
   input wire logic rsp_err // refusal
);
   initial begin
      cmd_valid = 1'b0;
      cmd_wr = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end
   // one word per command, bytes in the low half
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                       output logic [15:0] rd, output logic err, output logic ok);
      @(negedge core_clk);
      cmd_valid = 1'b1;
      cmd_wr = wr;
      cmd_code = code;
      cmd_wdata = wd;
      @(negedge core_clk);
      ok = rsp_valid;
      rd = rsp_data;
      err = rsp_err;
      // idle qualifiers scrambled so nothing leans on stale values
      cmd_valid = 1'b0;
      cmd_wr = ~wr;
      cmd_code = ~code;
      cmd_wdata = ~wd;
   endtask
endmodule // tvfs_host_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top import tvfs_pkg::*; ;
   // --------
   // stimulus values, linear-11 with exponent 0
   // --------
   localparam logic [15:0] T_OK = 16'h0019, T_WRN = 16'h07D3, T_FLT = 16'h07C4;
   localparam logic [15:0] V_OK = 16'h000C, V_OVW = 16'h000E, V_OVF = 16'h0010;
   localparam logic [15:0] V_UVW = 16'h0004, V_UVF = 16'h0002, STRAP = 16'h0003;
   logic core_clk, rst_b, cmd_valid, cmd_wr, rsp_valid, rsp_err;
   logic sample_valid, rail_en, pwr_en, smbalert_b;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, rsp_data, temp_l11, vin_l11, uv_strap_l11;
   int miscompares, compares;

   tvfs_supervisor #(.TICK_CYC(4)) dut (.core_clk, .rst_b, .cmd_valid, .cmd_wr, .cmd_code,
      .cmd_wdata, .rsp_valid, .rsp_data, .rsp_err, .temp_l11, .vin_l11, .sample_valid,
      .rail_en, .uv_strap_l11, .pwr_en, .smbalert_b);
   tvfs_host_model host (.core_clk, .cmd_valid, .cmd_wr, .cmd_code, .cmd_wdata,
      .rsp_valid, .rsp_data, .rsp_err);

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic finish_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, e);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic chkb(input logic s, e);
      chk({15'h0, s}, {15'h0, e});
   endtask
   // e[16] is the expected refusal flag
   task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] wd, input logic [16:0] e);
      logic [15:0] d;
      logic er;
      logic ok;
      host.xfer(w, c, wd, d, er, ok);
      chkb(ok, 1'b1);
      chkb(er, e[16]);
      if (!w) chk(d, e[15:0]);
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] wd);
      acc(1'b1, c, wd, 17'h0);
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      acc(1'b0, c, 16'h0, {1'b0, e});
   endtask
   task automatic smp(input logic [15:0] t, v);
      @(negedge core_clk);
      temp_l11 = t;
      vin_l11 = v;
      sample_valid = 1'b1;
      @(negedge core_clk);
      sample_valid = 1'b0;
   endtask
   task automatic wait_pwr(input logic e, input int n);
      for (int i = 0; i < n && pwr_en !== e; i++) @(negedge core_clk);
      chkb(pwr_en, e);
      if (pwr_en !== e) finish_test();
   endtask
   // rail_en low is the only restart for a latched engine
   task automatic rst_eng(input logic [7:0] c);
      smp(T_OK, V_OK);
      rail_en = 1'b0;
      repeat (2) @(negedge core_clk);
      rail_en = 1'b1;
      wr(CMD_CLEAR_FAULTS, 16'h0);
      wr(c, 16'h0080);
      wait_pwr(1'b1, 5);
   endtask

   // --------
   // scenarios
   // --------
   task automatic sc_regs();
      rd(CMD_UT_WARN, RST_UT_WARN);
      rd(CMD_UT_FAULT, RST_UT_FAULT);
      rd(CMD_UT_ACT, {8'h00, RST_ACT});
      rd(CMD_OV_FAULT, RST_OV_FAULT);
      rd(CMD_OV_ACT, {8'h00, RST_ACT});
      rd(CMD_OV_WARN, RST_OV_WARN);
      rd(CMD_UV_WARN, RST_UV_WARN);
      rd(CMD_UV_FAULT, STRAP);
      rd(CMD_UV_ACT, {8'h00, RST_ACT});
      rd(CMD_STATUS_WORD, 16'h0000);
      wr(CMD_UT_FAULT, 16'hE491);
      rd(CMD_UT_FAULT, 16'hE491);
      wr(CMD_UT_FAULT, RST_UT_FAULT);
      wr(CMD_UV_ACT, 16'hFF80);
      rd(CMD_UV_ACT, 16'h0080);
      acc(1'b1, CMD_STATUS_WORD, 16'h0001, 17'h10000);
      acc(1'b0, 8'hFF, 16'h0, 17'h10000);
   endtask
   task automatic sc_warn();
      smp(T_WRN, V_OK);
      rd(CMD_STATUS_TEMP, 16'h0020);
      rd(CMD_STATUS_BYTE, 16'h0004);
      chkb(smbalert_b, 1'b0);
      chkb(pwr_en, 1'b1);
      smp(T_OK, V_OVW);
      rd(CMD_STATUS_INPUT, 16'h0040);
      rd(CMD_STATUS_WORD, 16'h2005);
      smp(T_OK, V_UVW);
      rd(CMD_STATUS_INPUT, 16'h0060);
      smp(T_OK, V_OK);
      chkb(smbalert_b, 1'b0);
      wr(CMD_CLEAR_FAULTS, 16'h0);
      chkb(smbalert_b, 1'b1);
      rd(CMD_STATUS_WORD, 16'h0000);
   endtask
   task automatic sc_latch();
      smp(T_FLT, V_OK);
      chkb(pwr_en, 1'b1);
      @(negedge core_clk);
      chkb(pwr_en, 1'b1);
      @(negedge core_clk);
      chkb(pwr_en, 1'b0);
      smp(T_OK, V_OK);
      repeat (20) @(negedge core_clk);
      chkb(pwr_en, 1'b0);
      rd(CMD_STATUS_TEMP, 16'h0030);
      rst_eng(CMD_UT_ACT);
   endtask
   task automatic hic(input logic [7:0] c, input logic [15:0] tf, vf, th, vh);
      wr(c, 16'h00C0);
      smp(tf, vf);
      wait_pwr(1'b0, 5);
      smp(th, vh);
      repeat (6) @(negedge core_clk);
      chkb(pwr_en, 1'b0);
      smp(T_OK, V_OK);
      wait_pwr(1'b1, 5);
      rst_eng(c);
   endtask
   task automatic rty(input logic [7:0] a, input logic [15:0] t);
      wr(CMD_UT_ACT, {8'h00, a});
      smp(T_FLT, V_OK);
      wait_pwr(1'b0, 5);
      smp(t, V_OK);
      wait_pwr(1'b1, 40);
      rst_eng(CMD_UT_ACT);
   endtask
   // fault never clears, so the attempts run out and the output stays off
   task automatic sc_rty_latch();
      wr(CMD_UT_ACT, 16'h0091);
      smp(T_FLT, V_OK);
      wait_pwr(1'b0, 5);
      repeat (30) @(negedge core_clk);
      chkb(pwr_en, 1'b0);
      rst_eng(CMD_UT_ACT);
   endtask

   initial begin
      miscompares = 0;
      compares = 0;
      rst_b = 1'b0;
      rail_en = 1'b1;
      sample_valid = 1'b0;
      temp_l11 = T_OK;
      vin_l11 = V_OK;
      uv_strap_l11 = STRAP;
      repeat (5) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge core_clk);
      sc_regs();
      sc_warn();
      sc_latch();
      hic(CMD_UT_ACT, T_FLT, V_OK, T_WRN, V_OK);
      hic(CMD_UV_ACT, T_OK, V_UVF, T_OK, V_UVW);
      hic(CMD_OV_ACT, T_OK, V_OVF, T_OK, V_OVF);
      wr(CMD_OV_ACT, 16'h0000);
      smp(T_OK, V_OVF);
      repeat (6) @(negedge core_clk);
      chkb(pwr_en, 1'b1);
      rd(CMD_STATUS_INPUT, 16'h00C0);
      rst_eng(CMD_OV_ACT);
      wr(CMD_UT_ACT, 16'h0042);
      smp(T_FLT, V_OK);
      repeat (4) @(negedge core_clk);
      chkb(pwr_en, 1'b1);
      wait_pwr(1'b0, 20);
      rst_eng(CMD_UT_ACT);
      rty(8'h91, T_OK);
      rty(8'hB9, T_FLT);
      sc_rty_latch();
      finish_test();
   end
endmodule // tb_top
